//--- rtl/selfprog_pkg.sv
// Package for the flash self-programming controller: register map, fields, timing.
// Assumes a 50 MHz core clock and a CPU core that presents register and store/load strobes.
package selfprog_pkg;

   localparam logic [5:0] CSR_OFFSET = 6'h37;
   localparam logic [7:0] CSR_RESET = 8'h00;
   localparam int BIT_IRQ_EN = 7;
   localparam int BIT_BUSY = 6;
   localparam int BIT_RSVD = 5;

   // Lower five bits of a command write.
   localparam logic [4:0] CMD_REENABLE = 5'h11;
   localparam logic [4:0] CMD_LOCK = 5'h09;
   localparam logic [4:0] CMD_PGWRITE = 5'h05;
   localparam logic [4:0] CMD_PGERASE = 5'h03;
   localparam logic [4:0] CMD_FILL = 5'h01;

   localparam logic [2:0] ARM_CYCLES = 3'h4;
   localparam logic [1:0] LPM_CYCLES = 2'h3;

   localparam logic [12:0] BOOT_END = 13'h1fff;
   localparam logic [12:0] BOOT_START_128 = 13'h1f80;
   localparam logic [12:0] BOOT_START_256 = 13'h1f00;
   localparam logic [12:0] BOOT_START_512 = 13'h1e00;
   localparam logic [12:0] BOOT_START_1024 = 13'h1c00;
   localparam logic [12:0] STALL_SECTION_START = 13'h1c00;
   localparam logic [6:0] STALL_FIRST_PAGE = 7'h70;

   localparam int CLK_MHZ = 50;
   localparam int PROG_MIN_US = 3700;
   localparam int PROG_MAX_US = 4500;
   localparam int PROG_CYCLES = PROG_MIN_US * CLK_MHZ;

   typedef struct packed {
      logic [6:0] page;
      logic [5:0] word;
      logic byte_sel;
   } zaddr_t;

   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_ARMED = 5'b00010,
      ST_ERASE = 5'b00100,
      ST_WRITE = 5'b01000,
      ST_LOCK = 5'b10000
   } sp_state_t;

   // Maps the 16-bit pointer to page, word and byte select; bits 15 and 14 are dropped.
   function automatic zaddr_t split_pointer(input logic [15:0] z);
      zaddr_t a;
      a.page = z[13:7];
      a.word = z[6:1];
      a.byte_sel = z[0];
      return a;
   endfunction

endpackage

//--- rtl/boot_section_map.sv
// Boot section decoder: start address from the boot-size fuses, and section tests.
// Assumes fuse levels are static while the core runs.
`timescale 1ns/10ps
`default_nettype none
module boot_section_map
   import selfprog_pkg::*;
(
   input wire logic i_boot_size_hi,
   input wire logic i_boot_size_lo,
   input wire logic [12:0] i_word_addr,
   output logic [12:0] o_boot_start,
   output logic o_in_boot,
   output logic o_in_stall_section
);
   always_comb begin
      unique case ({i_boot_size_hi, i_boot_size_lo})
         2'h3: o_boot_start = BOOT_START_128;
         2'h2: o_boot_start = BOOT_START_256;
         2'h1: o_boot_start = BOOT_START_512;
         2'h0: o_boot_start = BOOT_START_1024;
      endcase
   end
   assign o_in_boot = (i_word_addr >= o_boot_start) && (i_word_addr <= BOOT_END);
   assign o_in_stall_section = i_word_addr >= STALL_SECTION_START;
endmodule // boot_section_map
`default_nettype wire

//--- rtl/arm_window.sv
// Arming window counter: loaded on a valid command write, flags expiry.
// Assumes the store strobe of the core is a one-cycle pulse.
`timescale 1ns/10ps
`default_nettype none
module arm_window
   import selfprog_pkg::*;
#(
   parameter logic [2:0] WIDTH_CYCLES = ARM_CYCLES
)(
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   input wire logic i_load,
   input wire logic i_consume,
   output logic o_open,
   output logic o_expire
);
   logic [2:0] count;
   logic [2:0] next_count;
   always_comb begin
      next_count = count;
      if (i_load) begin
         next_count = WIDTH_CYCLES;
      end else if (i_consume) begin
         next_count = 3'h0;
      end else if (count != 3'h0) begin
         next_count = count - 3'h1;
      end
   end
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         count <= 3'h0;
      end else begin
         count <= next_count;
      end
   end
   assign o_open = count != 3'h0;
   // Expiry in the last cycle of the window, unless a store or a new load lands there.
   assign o_expire = (count == 3'h1) && !i_consume && !i_load;
endmodule // arm_window
`default_nettype wire

//--- rtl/flash_self_program_ctrl.sv
// Self-programming controller: control/status register, store decode, program timer.
// Assumes a core that drives register strobes and one-cycle store/load pulses with Z, R0.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - Boot size from fuses, ends 0x1FFF.
// - Sections split at word 0x1C00.
// - 64-word pages, word from Z6:Z1.
// - Page number from Z13:Z7.
// - Z15:Z14 ignored; Z0 selects load byte.
// - Ready interrupt while enable bit clear.
// - Busy flag set on section program.
// - Busy cleared by re-enable or fill.
// - Re-enable refused while programming busy.
// - Re-enable during fill discards buffer.
// - Lock command programs lock bits from R0.
// - Lock bit clears on completion or timeout.
// - Load within three cycles reads lock/fuse.
// - Page write command writes buffer to page.
// - Write bit clears on completion or timeout.
// - CPU halted when programming stall section.
// - Page erase command erases addressed page.
// - Erase bit clears on completion or timeout.
// - Plain enable stores R1:R0 into buffer.
// - Enable held through erase or write.
// - Only five command patterns are accepted.
// - Programming lasts 3.7 to 4.5 ms; the default timer counts only the 3.7 ms minimum.
module flash_self_program_ctrl
   import selfprog_pkg::*;
#(
   parameter int PROG_TIME_CYCLES = PROG_CYCLES
)(
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [5:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_global_irq_en,
   input wire logic i_spm_strobe,
   input wire logic i_lpm_strobe,
   input wire logic [15:0] i_z_pointer,
   input wire logic [15:0] i_r1r0,
   input wire logic i_boot_size_hi,
   input wire logic i_boot_size_lo,
   input wire logic [7:0] i_lock_bits,
   input wire logic [7:0] i_fuse_bits,
   output logic [7:0] o_reg_rdata,
   output logic o_ready_irq,
   output logic o_rw_section_busy,
   output logic o_cpu_halt,
   output logic o_buf_we,
   output logic [5:0] o_buf_word,
   output logic [15:0] o_buf_data,
   output logic o_buf_discard,
   output logic o_flash_erase,
   output logic o_flash_write,
   output logic [6:0] o_flash_page,
   output logic o_lock_we,
   output logic [7:0] o_lock_data,
   output logic o_lpm_special,
   output logic [7:0] o_lpm_data,
   output logic [12:0] o_boot_start
);

   typedef struct packed {
      sp_state_t st;
      logic irq_en;
      logic busy;
      logic [4:0] cmd;
      logic [31:0] timer;
      logic filling;
      logic [1:0] lpm_win;
      logic [7:0] rdata;
      logic irq;
      logic halt;
      logic buf_we;
      logic [5:0] buf_word;
      logic [15:0] buf_data;
      logic discard;
      logic erase;
      logic write;
      logic [6:0] page;
      logic lock_we;
      logic [7:0] lock_data;
      logic lpm_sp;
      logic [7:0] lpm_data;
      logic [12:0] boot_start;
   } ctrl_state_t;

   ctrl_state_t s;
   ctrl_state_t next_s;

   zaddr_t za;
   logic cmd_write;
   logic cmd_valid;
   logic win_open;
   logic win_expire;
   logic store_hit;
   logic [12:0] boot_start;
   logic target_stall;

   assign za = split_pointer(i_z_pointer);
   assign cmd_write = i_reg_wr && (i_reg_addr == CSR_OFFSET);
   // Only accepted while idle; a write during programming cannot start a second one.
   assign cmd_valid = cmd_write && (s.st == ST_IDLE) &&
      (i_reg_wdata[4:0] == CMD_REENABLE || i_reg_wdata[4:0] == CMD_LOCK ||
       i_reg_wdata[4:0] == CMD_PGWRITE || i_reg_wdata[4:0] == CMD_PGERASE ||
       i_reg_wdata[4:0] == CMD_FILL);
   assign store_hit = i_spm_strobe && (s.st == ST_ARMED) && win_open;

   arm_window u_arm_window (
      .i_core_clk(i_core_clk),
      .i_rst_b(i_rst_b),
      .i_load(cmd_valid),
      .i_consume(store_hit),
      .o_open(win_open),
      .o_expire(win_expire)
   );

   boot_section_map u_boot_section_map (
      .i_boot_size_hi(i_boot_size_hi),
      .i_boot_size_lo(i_boot_size_lo),
      .i_word_addr({za.page, za.word}),
      .o_boot_start(boot_start),
      .o_in_boot(),
      .o_in_stall_section(target_stall)
   );

   always_comb begin
      next_s = s;
      next_s.buf_we = 1'b0;
      next_s.discard = 1'b0;
      next_s.erase = 1'b0;
      next_s.write = 1'b0;
      next_s.lock_we = 1'b0;
      next_s.lpm_sp = 1'b0;
      next_s.boot_start = boot_start;
      if (s.lpm_win != 2'h0) begin
         next_s.lpm_win = s.lpm_win - 2'h1;
      end
      if (cmd_write) begin
         next_s.irq_en = i_reg_wdata[BIT_IRQ_EN];
      end
      unique case (s.st)
         ST_IDLE: begin
            if (cmd_valid) begin
               next_s.cmd = i_reg_wdata[4:0];
               next_s.st = ST_ARMED;
               if (i_reg_wdata[4:0] == CMD_LOCK) begin
                  next_s.lpm_win = LPM_CYCLES;
               end
               if (i_reg_wdata[4:0] == CMD_REENABLE && s.filling) begin
                  next_s.filling = 1'b0;
                  next_s.discard = 1'b1;
               end
            end
         end
         ST_ARMED: begin
            if (win_expire) begin
               next_s.cmd = 5'h00;
               next_s.st = ST_IDLE;
            end else if (store_hit) begin
               next_s.timer = PROG_TIME_CYCLES;
               next_s.page = za.page;
               unique case (s.cmd)
                  CMD_REENABLE: begin
                     next_s.busy = 1'b0;
                     next_s.cmd = 5'h00;
                     next_s.st = ST_IDLE;
                  end
                  CMD_LOCK: begin
                     next_s.lock_we = 1'b1;
                     next_s.lock_data = i_r1r0[7:0];
                     next_s.st = ST_LOCK;
                  end
                  CMD_PGWRITE: begin
                     next_s.write = 1'b1;
                     next_s.filling = 1'b0;
                     next_s.st = ST_WRITE;
                  end
                  CMD_PGERASE: begin
                     next_s.erase = 1'b1;
                     next_s.st = ST_ERASE;
                  end
                  default: begin
                     next_s.buf_we = 1'b1;
                     next_s.buf_word = za.word;
                     next_s.buf_data = i_r1r0;
                     next_s.filling = 1'b1;
                     next_s.busy = 1'b0;
                     next_s.cmd = 5'h00;
                     next_s.st = ST_IDLE;
                  end
               endcase
               if ((s.cmd == CMD_PGWRITE) || (s.cmd == CMD_PGERASE)) begin
                  if (target_stall) begin
                     next_s.halt = 1'b1;
                  end else begin
                     next_s.busy = 1'b1;
                  end
               end
            end
         end
         ST_ERASE, ST_WRITE, ST_LOCK: begin
            // Enable stays high until the timer runs out.
            if (s.timer <= 32'h1) begin
               next_s.cmd = 5'h00;
               next_s.halt = 1'b0;
               next_s.st = ST_IDLE;
            end else begin
               next_s.timer = s.timer - 32'h1;
            end
         end
      endcase
      if (i_lpm_strobe && s.lpm_win != 2'h0 && s.cmd == CMD_LOCK) begin
         next_s.lpm_sp = 1'b1;
         next_s.lpm_data = za.byte_sel ? i_fuse_bits : i_lock_bits;
      end
      next_s.irq = next_s.irq_en && i_global_irq_en && !next_s.cmd[0];
      next_s.rdata = 8'h00;
      if (i_reg_rd && i_reg_addr == CSR_OFFSET) begin
         next_s.rdata = {s.irq_en, s.busy, 1'b0, s.cmd};
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         s <= '0;
         s.st <= ST_IDLE;
      end else begin
         s <= next_s;
      end
   end

   assign o_reg_rdata = s.rdata;
   assign o_ready_irq = s.irq;
   assign o_rw_section_busy = s.busy;
   assign o_cpu_halt = s.halt;
   assign o_buf_we = s.buf_we;
   assign o_buf_word = s.buf_word;
   assign o_buf_data = s.buf_data;
   assign o_buf_discard = s.discard;
   assign o_flash_erase = s.erase;
   assign o_flash_write = s.write;
   assign o_flash_page = s.page;
   assign o_lock_we = s.lock_we;
   assign o_lock_data = s.lock_data;
   assign o_lpm_special = s.lpm_sp;
   assign o_lpm_data = s.lpm_data;
   assign o_boot_start = s.boot_start;

endmodule // flash_self_program_ctrl
`default_nettype wire

//--- tb/flash_self_program_ctrl_asserts.sv
// Port checker for the self-programming controller.
// Assumes it is bound into the controller and sees a short program time.
`timescale 1ns/10ps
`default_nettype none
module fsp_checker
   import selfprog_pkg::*;
#(
   parameter int PROG_TIME_CYCLES = PROG_CYCLES
)(
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   input wire logic i_reg_rd,
   input wire logic i_global_irq_en,
   input wire logic i_spm_strobe,
   input wire logic [15:0] i_z_pointer,
   input wire logic [15:0] i_r1r0,
   input wire logic [7:0] i_lock_bits,
   input wire logic [7:0] i_fuse_bits,
   input wire logic [7:0] o_reg_rdata,
   input wire logic o_ready_irq,
   input wire logic o_rw_section_busy,
   input wire logic o_cpu_halt,
   input wire logic o_buf_we,
   input wire logic [5:0] o_buf_word,
   input wire logic [15:0] o_buf_data,
   input wire logic o_flash_erase,
   input wire logic o_flash_write,
   input wire logic [6:0] o_flash_page,
   input wire logic o_lock_we,
   input wire logic [7:0] o_lock_data,
   input wire logic o_lpm_special,
   input wire logic [7:0] o_lpm_data
);
   int halt_cnt;
   logic prog;
   assign prog = o_flash_erase || o_flash_write;
   // A counter, since the real program time is far beyond any delay range.
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         halt_cnt <= 0;
      end else begin
         halt_cnt <= o_cpu_halt ? halt_cnt + 1 : 0;
      end
   end
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_b);
   a_rsvd_zero: assert property (o_reg_rdata[BIT_RSVD] == 1'b0)
      else $error("reserved bit read as one");
   a_irq_gate: assert property (!i_global_irq_en |=> !o_ready_irq)
      else $error("ready interrupt without global enable");
   a_busy_cause: assert property ($rose(o_rw_section_busy) |->
      prog && o_flash_page < STALL_FIRST_PAGE)
      else $error("busy set without concurrent section program");
   a_halt_cause: assert property ($rose(o_cpu_halt) |->
      prog && o_flash_page >= STALL_FIRST_PAGE)
      else $error("halt without stall section program");
   a_halt_time: assert property ($fell(o_cpu_halt) |->
      halt_cnt >= PROG_TIME_CYCLES - 1 && halt_cnt <= PROG_TIME_CYCLES + 2)
      else $error("halt length wrong");
   a_page_map: assert property (prog |-> o_flash_page == $past(i_z_pointer[13:7]))
      else $error("page number not from pointer");
   a_fill_map: assert property (o_buf_we |->
      o_buf_word == $past(i_z_pointer[6:1]) && o_buf_data == $past(i_r1r0))
      else $error("buffer fill word or data wrong");
   a_lock_data: assert property (o_lock_we |-> o_lock_data == $past(i_r1r0[7:0]))
      else $error("lock data not from low register");
   a_load_sel: assert property (o_lpm_special |->
      o_lpm_data == ($past(i_z_pointer[0]) ? $past(i_fuse_bits) : $past(i_lock_bits)))
      else $error("special load selection wrong");
   a_store_needed: assert property ((prog || o_lock_we || o_buf_we) |->
      $past(i_spm_strobe))
      else $error("action without store");
   a_read_idle: assert property (!i_reg_rd |=> o_reg_rdata == 8'h00)
      else $error("read data outside read");
   c_halt: cover property ($rose(o_cpu_halt));
   c_busy: cover property ($rose(o_rw_section_busy));
   c_load: cover property (o_lpm_special);
endmodule // fsp_checker
bind flash_self_program_ctrl fsp_checker #(.PROG_TIME_CYCLES(PROG_TIME_CYCLES)) u_chk (
   .i_core_clk(i_core_clk),
   .i_rst_b(i_rst_b),
   .i_reg_rd(i_reg_rd),
   .i_global_irq_en(i_global_irq_en),
   .i_spm_strobe(i_spm_strobe),
   .i_z_pointer(i_z_pointer),
   .i_r1r0(i_r1r0),
   .i_lock_bits(i_lock_bits),
   .i_fuse_bits(i_fuse_bits),
   .o_reg_rdata(o_reg_rdata),
   .o_ready_irq(o_ready_irq),
   .o_rw_section_busy(o_rw_section_busy),
   .o_cpu_halt(o_cpu_halt),
   .o_buf_we(o_buf_we),
   .o_buf_word(o_buf_word),
   .o_buf_data(o_buf_data),
   .o_flash_erase(o_flash_erase),
   .o_flash_write(o_flash_write),
   .o_flash_page(o_flash_page),
   .o_lock_we(o_lock_we),
   .o_lock_data(o_lock_data),
   .o_lpm_special(o_lpm_special),
   .o_lpm_data(o_lpm_data)
);
`default_nettype wire

//--- tb/core_model.sv
// Behavioural core issuing register accesses, stores and loads.
// Assumes each task is entered at a falling edge; each returns at one.
`timescale 1ns/10ps
`default_nettype none
module core_model
   import selfprog_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic [7:0] i_reg_rdata,
   output logic o_reg_wr,
   output logic o_reg_rd,
   output logic [5:0] o_reg_addr,
   output logic [7:0] o_reg_wdata,
   output logic o_spm,
   output logic o_lpm,
   output logic [15:0] o_z,
   output logic [15:0] o_r1r0
);
   initial begin
      o_reg_wr = 1'b0;
      o_reg_rd = 1'b0;
      o_reg_addr = 6'h00;
      o_reg_wdata = 8'h00;
      o_spm = 1'b0;
      o_lpm = 1'b0;
      o_z = 16'h0000;
      o_r1r0 = 16'h0000;
   end
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      o_reg_addr = a;
      o_reg_wdata = d;
      o_reg_wr = 1'b1;
      @(negedge i_core_clk);
      o_reg_wr = 1'b0;
      o_reg_wdata = ~d;
   endtask
   task automatic rd(output logic [7:0] d);
      o_reg_addr = CSR_OFFSET;
      o_reg_rd = 1'b1;
      @(negedge i_core_clk);
      o_reg_rd = 1'b0;
      d = i_reg_rdata;
   endtask
   // Stores keep Z0 low and set the ignored top bits; page writes pass word 0.
   task automatic spm(input logic [6:0] pg, input logic [5:0] wd, input logic [15:0] d);
      o_z = {2'h3, pg, wd, 1'b0};
      o_r1r0 = d;
      o_spm = 1'b1;
      @(negedge i_core_clk);
      o_spm = 1'b0;
   endtask
   task automatic lpm(input logic z0);
      o_z = {15'h0000, z0};
      o_lpm = 1'b1;
      @(negedge i_core_clk);
      o_lpm = 1'b0;
   endtask
endmodule // core_model
`default_nettype wire

//--- tb/flash_self_program_ctrl_tb_top.sv
// Testbench of the self-programming controller.
// Assumes the core model drives every request at falling edges.
`timescale 1ns/10ps
`default_nettype none
module flash_self_program_ctrl_tb_top
   import selfprog_pkg::*;
;
   logic i_core_clk, i_rst_b, i_reg_wr, i_reg_rd, i_global_irq_en, i_spm_strobe, i_lpm_strobe;
   logic [5:0] i_reg_addr;
   logic [7:0] i_reg_wdata, i_lock_bits, i_fuse_bits, o_reg_rdata, o_lock_data, o_lpm_data, d;
   logic [15:0] i_z_pointer, i_r1r0, o_buf_data;
   logic i_boot_size_hi, i_boot_size_lo, o_ready_irq, o_rw_section_busy, o_cpu_halt;
   logic o_buf_we, o_buf_discard, o_flash_erase, o_flash_write, o_lock_we, o_lpm_special;
   logic [5:0] o_buf_word;
   logic [6:0] o_flash_page;
   logic [12:0] o_boot_start;
   logic [12:0] boot_exp [4] = '{BOOT_START_1024, BOOT_START_512, BOOT_START_256, BOOT_START_128};
   int mismatches = 0;
   int num_checks = 0;
   int cyc = 0;
   flash_self_program_ctrl #(.PROG_TIME_CYCLES(20)) dut (.*);
   core_model core (.i_core_clk(i_core_clk), .i_reg_rdata(o_reg_rdata), .o_reg_wr(i_reg_wr),
      .o_reg_rd(i_reg_rd), .o_reg_addr(i_reg_addr), .o_reg_wdata(i_reg_wdata),
      .o_spm(i_spm_strobe), .o_lpm(i_lpm_strobe), .o_z(i_z_pointer), .o_r1r0(i_r1r0));
   always #10 i_core_clk = ~i_core_clk;
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic w(input int n);
      repeat (n) @(negedge i_core_clk);
   endtask
   task automatic cmd(input logic [4:0] c);
      core.wr(CSR_OFFSET, {3'h0, c});
   endtask
   // The whole run takes under two hundred cycles; this ceiling only stops a hang.
   always @(posedge i_core_clk) begin
      cyc++;
      if (cyc == 3000) begin
         mismatches++;
         results();
      end
   end
   initial begin
      i_core_clk = 1'b0;
      i_rst_b = 1'b0;
      i_global_irq_en = 1'b0;
      {i_boot_size_hi, i_boot_size_lo} = 2'h3;
      i_lock_bits = 8'h3c;
      i_fuse_bits = 8'hd9;
      w(10);
      i_rst_b = 1'b1;
      core.rd(d);
      chk("csr reset", 16'h0000, {8'h00, d});
      for (int i = 0; i < 4; i++) begin
         {i_boot_size_hi, i_boot_size_lo} = 2'(i);
         w(2);
         chk("boot start", {3'h0, boot_exp[i]}, {3'h0, o_boot_start});
      end
      $display("test boot map done");
      i_global_irq_en = 1'b1;
      core.wr(CSR_OFFSET, 8'he0);
      core.rd(d);
      chk("csr masked", 16'h0080, {8'h00, d});
      chk("irq on", 16'h0001, {15'h0000, o_ready_irq});
      i_global_irq_en = 1'b0;
      w(2);
      chk("irq off", 16'h0000, {15'h0000, o_ready_irq});
      cmd(5'h00);
      core.rd(d);
      chk("irq enable off", 16'h0000, {8'h00, d});
      core.wr(6'h3f, 8'h03);
      core.rd(d);
      chk("unmapped", 16'h0000, {8'h00, d});
      cmd(5'h07);
      core.rd(d);
      chk("bad pattern", 16'h0000, {8'h00, d});
      $display("test register done");
      cmd(CMD_FILL);
      core.spm(7'h00, 6'h05, 16'habcd);
      chk("fill we", 16'h0001, {15'h0000, o_buf_we});
      chk("fill word", 16'h0005, {10'h000, o_buf_word});
      chk("fill data", 16'habcd, o_buf_data);
      core.rd(d);
      chk("fill done", 16'h0000, {8'h00, d});
      cmd(CMD_PGERASE);
      core.spm(7'h05, 6'h00, 16'h0000);
      chk("erase", 16'h0001, {15'h0000, o_flash_erase});
      chk("erase page", 16'h0005, {9'h000, o_flash_page});
      chk("busy", 16'h0001, {15'h0000, o_rw_section_busy});
      core.rd(d);
      chk("csr erasing", 16'h0043, {8'h00, d});
      // A re-enable and its store while erasing must leave the busy flag set.
      cmd(CMD_REENABLE);
      core.spm(7'h00, 6'h00, 16'h0000);
      w(24);
      core.rd(d);
      chk("erase end", 16'h0040, {8'h00, d});
      cmd(CMD_REENABLE);
      chk("discard", 16'h0001, {15'h0000, o_buf_discard});
      core.spm(7'h00, 6'h00, 16'h0000);
      chk("reenable", 16'h0000, {15'h0000, o_rw_section_busy});
      cmd(CMD_PGERASE);
      core.spm(7'h05, 6'h00, 16'h0000);
      w(25);
      cmd(CMD_FILL);
      core.spm(7'h00, 6'h00, 16'h1234);
      chk("fill unbusy", 16'h0000, {15'h0000, o_rw_section_busy});
      $display("test erase done");
      cmd(CMD_PGWRITE);
      core.spm(STALL_FIRST_PAGE, 6'h00, 16'h0000);
      chk("write", 16'h0001, {15'h0000, o_flash_write});
      chk("write page", 16'h0070, {9'h000, o_flash_page});
      chk("halt", 16'h0001, {15'h0000, o_cpu_halt});
      chk("no busy", 16'h0000, {15'h0000, o_rw_section_busy});
      w(25);
      chk("halt end", 16'h0000, {15'h0000, o_cpu_halt});
      core.rd(d);
      chk("write end", 16'h0000, {8'h00, d});
      $display("test stall write done");
      cmd(CMD_LOCK);
      core.spm(7'h00, 6'h00, 16'h125a);
      chk("lock we", 16'h0001, {15'h0000, o_lock_we});
      chk("lock data", 16'h005a, {8'h00, o_lock_data});
      w(25);
      core.rd(d);
      chk("lock end", 16'h0000, {8'h00, d});
      for (int k = 0; k < 2; k++) begin
         cmd(CMD_LOCK);
         core.lpm(k[0]);
         chk("load special", 16'h0001, {15'h0000, o_lpm_special});
         chk("load data", {8'h00, k[0] ? i_fuse_bits : i_lock_bits},
            {8'h00, o_lpm_data});
         w(6);
      end
      $display("test lock done");
      cmd(CMD_PGWRITE);
      w(6);
      core.rd(d);
      chk("expired", 16'h0000, {8'h00, d});
      core.spm(7'h01, 6'h00, 16'h0000);
      chk("late store", 16'h0000, {15'h0000, o_flash_write});
      $display("test expiry done");
      results();
   end
endmodule // flash_self_program_ctrl_tb_top
`default_nettype wire
